// [shared/pts_pkg.sv]
// Constants, register map and carrier types of the programmable threshold stage.
package pts_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELTA_MS = 20;
  localparam int DSTEP_MS = 5;
  localparam int DDEPTH = DELTA_MS / DSTEP_MS;
  localparam logic [2:0] DSTEP_LAST = 3'(DSTEP_MS - 1);
  localparam logic [31:0] ONE_X = 32'h0001_0000;
  localparam logic [31:0] PU_RST = 32'h0000_0064;
  localparam logic [31:0] HYS_RST = 32'h0000_7530;
  localparam logic [31:0] HYS_K = 32'h0010_c6f8;
  localparam logic signed [71:0] PCT = 72'sh0f_4240;
  localparam logic [20:0] OPD_RST = 21'h00_0028;
  localparam logic [20:0] REL_RST = 21'h00_003c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [5:0] DIV_BITS = 6'h30;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OPD = 8'h04;
  localparam logic [7:0] A_REL = 8'h08;
  localparam logic [7:0] A_COND = 8'h0c;
  localparam logic [7:0] A_REMAIN = 8'h10;
  localparam logic [7:0] A_EXPECT = 8'h14;
  localparam logic [7:0] A_ISTAT = 8'h18;
  localparam logic [7:0] A_IMASK = 8'h1c;
  localparam logic [1:0] A_MAG_HI = 2'h1;
  localparam logic [3:0] A_RATIO_HI = 4'h8;
  localparam logic [3:0] A_SCALED_HI = 4'h9;
  localparam logic [1:0] F_MODE = 2'h0;
  localparam logic [1:0] F_PU = 2'h1;
  localparam logic [1:0] F_HYS = 2'h2;
  localparam logic [1:0] F_MULT = 2'h3;
  localparam int IRQ_START = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_BLOCK = 2;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1, ST_START = 4'h2, ST_TRIP = 4'h4, ST_BLOCKED = 4'h8
  } pts_cond_t;
  typedef enum logic [2:0] {
    CM_OVER, CM_OVER_ABS, CM_UNDER, CM_UNDER_ABS,
    CM_DREL_SGN, CM_DREL_ABS, CM_DVAL_SGN, CM_DVAL_ABS
  } pts_cmp_t;
  typedef enum logic [2:0] {
    BM_ON, BM_BLOCKED, BM_TEST, BM_TEST_BLK, BM_OFF
  } pts_beh_t;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pts_avs_req_t;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } pts_stat_t;
endpackage

// [verilog/pts_programmable_stage.sv]
// Programmable threshold stage: scaling, comparators, timing and Avalon-MM registers.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module pts_programmable_stage
  import pts_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire pts_avs_req_t     avs,
  output logic [31:0]           avsReadData,
  output logic                  avsWaitRequest,
  input  wire logic [2:0][31:0] measIn,
  input  wire logic [31:0]      calcMag,
  input  wire logic             blockIn,
  input  wire logic             indivModeEn,
  output pts_stat_t             stat,
  output logic                  irq
);
  typedef struct packed {
    logic [31:0]                   ctrl;
    logic [20:0]                   opd;
    logic [20:0]                   rel;
    logic [2:0][2:0]               mode;
    logic [3:0][31:0]              pu;
    logic [2:0][31:0]              hys;
    logic [2:0][31:0]              mult;
    logic [2:0][31:0]              scaled;
    logic [3:0][31:0]              ratio;
    logic [2:0]                    puf;
    logic [DDEPTH-1:0][2:0][31:0]  hist;
    logic [31:0]                   tcnt;
    logic [2:0]                    dcnt;
    pts_cond_t                     cond;
    logic [20:0]                   remain;
    logic [20:0]                   relc;
    logic [2:0]                    ist;
    logic [2:0]                    imask;
    logic                          ack;
    logic [31:0]                   rdata;
    logic [1:0]                    di;
    logic [5:0]                    db;
    logic [47:0]                   dn;
    logic [47:0]                   dq;
    logic [32:0]                   dr;
    logic                          neg;
  } pts_state_t;

  pts_state_t s_reg;
  pts_state_t s_next;
  logic       tick;
  logic       pk;
  logic       blk;
  pts_beh_t   beh;
  logic [2:0] ev;

  function automatic logic [31:0] absv(input logic [31:0] v);
    return v[31] ? 32'h0 - v : v;
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] o, input pts_avs_req_t r);
    logic [31:0] m;
    m = {{8{r.byteenable[3]}}, {8{r.byteenable[2]}}, {8{r.byteenable[1]}},
         {8{r.byteenable[0]}}};
    return (o & ~m) | (r.writedata & m);
  endfunction

  // Hysteresis band: |pick-up| * hys / 1e6, hys in 0.0001 % steps.
  function automatic logic [31:0] band(input logic [31:0] p, input logic [31:0] h);
    logic [95:0] pr;
    pr = 96'(absv(p)) * 96'(h) * 96'(HYS_K);
    return pr[71:40];
  endfunction

  function automatic logic cmpf(input pts_cmp_t m, input logic [31:0] x,
                                input logic [31:0] o, input logic [31:0] p,
                                input logic [31:0] h, input logic prev);
    logic signed [34:0] xs;
    logic signed [34:0] os;
    logic signed [34:0] ps;
    logic signed [34:0] bs;
    logic signed [34:0] d;
    logic signed [34:0] ad;
    logic signed [34:0] ao;
    logic signed [34:0] ap;
    logic signed [71:0] ls;
    logic signed [71:0] la;
    logic signed [71:0] rs;
    logic signed [71:0] ra;
    logic               res;
    xs = $signed({{3{x[31]}}, x});
    os = $signed({{3{o[31]}}, o});
    ps = $signed({{3{p[31]}}, p});
    bs = $signed({3'h0, band(p, h)});
    d = xs - os;
    ad = d < 0 ? -d : d;
    ao = os < 0 ? -os : os;
    ap = ps < 0 ? -ps : ps;
    ls = 72'(d) * PCT;
    la = 72'(ad) * PCT;
    rs = 72'(ps) * 72'(ao);
    ra = 72'(ap) * 72'(ao);
    case (m)
      CM_OVER:      res = xs > (prev ? ps - bs : ps);
      CM_OVER_ABS:  res = (xs < 0 ? -xs : xs) > (prev ? ps - bs : ps);
      CM_UNDER:     res = xs < (prev ? ps + bs : ps);
      CM_UNDER_ABS: res = (xs < 0 ? -xs : xs) < (prev ? ps + bs : ps);
      CM_DREL_SGN:  res = ps >= 0 ? ls > rs : ls < rs;
      CM_DREL_ABS:  res = la > ra;
      CM_DVAL_SGN:  res = ps >= 0 ? d > ps : d < ps;
      CM_DVAL_ABS:  res = ad > ap;
      default:      res = 1'b0;
    endcase
    return res;
  endfunction

  assign tick = s_reg.tcnt == 32'(TICK_CYCLES - 1);
  assign beh = pts_beh_t'(s_reg.ctrl[4:2]);
  assign blk = blockIn || beh == BM_BLOCKED || beh == BM_TEST_BLK;

  // All selected comparisons must be fulfilled together for pick-up.
  always_comb
  begin
    pk = s_reg.puf[0];
    if (s_reg.ctrl[1:0] >= 2'h2)
    begin
      pk = pk && s_reg.puf[1];
    end
    if (s_reg.ctrl[1:0] == 2'h3)
    begin
      pk = pk && s_reg.puf[2];
    end
  end

  always_comb
  begin
    logic [63:0] prod;
    logic [32:0] rr;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] mag;
    logic [31:0] rd;
    logic [1:0]  ix;
    logic        wr;
    logic        rdclr;
    prod = '0;
    rr = '0;
    mag = '0;
    rd = '0;
    ix = avs.address[5:4];
    wr = avs.write && s_reg.ack;
    rdclr = avs.read && s_reg.ack && avs.address == A_ISTAT;
    s_next = s_reg;
    ev = '0;
    s_next.tcnt = tick ? 32'h0 : s_reg.tcnt + 32'h1;

    for (int i = 0; i < 3; i++)
    begin
      prod = $signed(measIn[i]) * $signed(s_reg.mult[i]);
      s_next.scaled[i] = prod[47:16];
    end

    if (tick)
    begin
      for (int i = 0; i < 3; i++)
      begin
        s_next.puf[i] = cmpf(pts_cmp_t'(s_reg.mode[i]), s_reg.scaled[i],
                             s_reg.hist[DDEPTH-1][i], s_reg.pu[i], s_reg.hys[i],
                             s_reg.puf[i]);
      end
      s_next.dcnt = s_reg.dcnt == DSTEP_LAST ? 3'h0 : s_reg.dcnt + 3'h1;
      if (s_reg.dcnt == DSTEP_LAST)
      begin
        s_next.hist = {s_reg.hist[DDEPTH-2:0], s_reg.scaled};
      end
      case (s_reg.cond)
        ST_NORMAL:
        begin
          s_next.relc = s_reg.rel;
          if (pk && blk)
          begin
            s_next.cond = ST_BLOCKED;
          end
          else if (pk)
          begin
            s_next.cond = ST_START;
            s_next.remain = s_reg.opd;
          end
        end
        ST_START:
        begin
          if (pk && !blk)
          begin
            s_next.relc = s_reg.rel;
            if (s_reg.remain <= 21'h1)
            begin
              s_next.cond = ST_TRIP;
              s_next.remain = '0;
            end
            else
            begin
              s_next.remain = s_reg.remain - 21'h1;
            end
          end
          else if (s_reg.relc <= 21'h1)
          begin
            s_next.cond = ST_NORMAL;
            s_next.remain = '0;
          end
          else
          begin
            s_next.relc = s_reg.relc - 21'h1;
          end
        end
        ST_TRIP:
        begin
          if (pk)
          begin
            s_next.relc = s_reg.rel;
          end
          else if (s_reg.relc <= 21'h1)
          begin
            s_next.cond = ST_NORMAL;
          end
          else
          begin
            s_next.relc = s_reg.relc - 21'h1;
          end
        end
        ST_BLOCKED:
        begin
          if (!pk)
          begin
            s_next.cond = ST_NORMAL;
          end
        end
        default:
        begin
          s_next.cond = ST_NORMAL;
        end
      endcase
    end
    if (beh == BM_OFF)
    begin
      s_next.cond = ST_NORMAL;
      s_next.remain = '0;
    end

    // One shared restoring divider walks the four ratios in turn.
    num = s_reg.di == 2'h3 ? calcMag : s_reg.scaled[s_reg.di];
    den = absv(s_reg.pu[s_reg.di]);
    if (s_reg.db == 6'h0)
    begin
      s_next.dn = {absv(num), 16'h0};
      s_next.dr = '0;
      s_next.dq = '0;
      s_next.neg = num[31] ^ s_reg.pu[s_reg.di][31];
      s_next.db = DIV_BITS;
    end
    else
    begin
      rr = {s_reg.dr[31:0], s_reg.dn[47]};
      s_next.dn = {s_reg.dn[46:0], 1'b0};
      s_next.dr = rr >= {1'b0, den} ? rr - {1'b0, den} : rr;
      s_next.dq = {s_reg.dq[46:0], rr >= {1'b0, den}};
      s_next.db = s_reg.db - 6'h1;
      if (s_reg.db == 6'h1)
      begin
        mag = |s_next.dq[47:31] ? 32'h7fff_ffff : s_next.dq[31:0];
        s_next.ratio[s_reg.di] = den == 32'h0 ? 32'h0 :
                                 (s_reg.neg ? 32'h0 - mag : mag);
        s_next.di = s_reg.di + 2'h1;
      end
    end

    ev[IRQ_START] = s_next.cond == ST_START && s_reg.cond != ST_START;
    ev[IRQ_TRIP] = s_next.cond == ST_TRIP && s_reg.cond != ST_TRIP;
    ev[IRQ_BLOCK] = s_next.cond == ST_BLOCKED && s_reg.cond != ST_BLOCKED;
    s_next.ist = (rdclr ? 3'h0 : s_reg.ist) | ev;

    // Register read mux; unmapped addresses read as zero.
    case (avs.address)
      A_CTRL:   rd = {26'h0, s_reg.ctrl[5:0]};
      A_OPD:    rd = {11'h0, s_reg.opd};
      A_REL:    rd = {11'h0, s_reg.rel};
      A_COND:   rd = {25'h0, indivModeEn ? s_reg.ctrl[4:2] : 3'h0, s_reg.cond};
      A_REMAIN: rd = {11'h0, s_reg.remain};
      A_EXPECT: rd = {11'h0, s_reg.opd};
      A_ISTAT:  rd = {29'h0, s_reg.ist};
      A_IMASK:  rd = {29'h0, s_reg.imask};
      default:
      begin
        if (avs.address[7:6] == A_MAG_HI && ix != 2'h3)
        begin
          case (avs.address[3:2])
            F_MODE:  rd = {29'h0, s_reg.mode[ix]};
            F_PU:    rd = s_reg.pu[ix];
            F_HYS:   rd = s_reg.hys[ix];
            default: rd = s_reg.mult[ix];
          endcase
        end
        else if (avs.address[7:6] == A_MAG_HI && avs.address[3:2] == F_PU)
        begin
          rd = s_reg.pu[3];
        end
        else if (avs.address[7:4] == A_RATIO_HI)
        begin
          rd = s_reg.ratio[avs.address[3:2]];
        end
        else if (avs.address[7:4] == A_SCALED_HI && avs.address[3:2] != 2'h3)
        begin
          rd = s_reg.scaled[avs.address[3:2]];
        end
      end
    endcase
    s_next.ack = (avs.read || avs.write) && !s_reg.ack;
    if (avs.read && !s_reg.ack)
    begin
      s_next.rdata = rd;
    end

    if (wr)
    begin
      case (avs.address)
        A_CTRL:  s_next.ctrl = upd(s_reg.ctrl, avs) & 32'h0000_003f;
        A_OPD:   s_next.opd = upd({11'h0, s_reg.opd}, avs) >> 0 == 0 ? '0 :
                              21'(upd({11'h0, s_reg.opd}, avs));
        A_REL:   s_next.rel = 21'(upd({11'h0, s_reg.rel}, avs));
        A_IMASK: s_next.imask = 3'(upd({29'h0, s_reg.imask}, avs));
        default:
        begin
          if (avs.address[7:6] == A_MAG_HI && ix != 2'h3)
          begin
            case (avs.address[3:2])
              F_MODE:  s_next.mode[ix] = 3'(upd({29'h0, s_reg.mode[ix]}, avs));
              F_PU:    s_next.pu[ix] = upd(s_reg.pu[ix], avs);
              F_HYS:   s_next.hys[ix] = upd(s_reg.hys[ix], avs);
              default: s_next.mult[ix] = upd(s_reg.mult[ix], avs);
            endcase
          end
          else if (avs.address[7:6] == A_MAG_HI && avs.address[3:2] == F_PU)
          begin
            s_next.pu[3] = upd(s_reg.pu[3], avs);
          end
        end
      endcase
    end

    if (srst)
    begin
      s_next = '0;
      s_next.ctrl = CTRL_RST;
      s_next.opd = OPD_RST;
      s_next.rel = REL_RST;
      s_next.mode = {3{CM_OVER}};
      s_next.pu = {4{PU_RST}};
      s_next.hys = {3{HYS_RST}};
      s_next.mult = {3{ONE_X}};
      s_next.cond = ST_NORMAL;
    end
  end

  always_ff @(posedge clk)
  begin
    s_reg <= s_next;
  end

  assign avsReadData = s_reg.rdata;
  assign avsWaitRequest = (avs.read || avs.write) && !s_reg.ack;
  assign stat.start = s_reg.cond == ST_START;
  assign stat.trip = s_reg.cond == ST_TRIP && beh != BM_TEST;
  assign stat.blocked = s_reg.cond == ST_BLOCKED;
  assign irq = |(s_reg.ist & s_reg.imask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_cond_onehot: assert property ($onehot(s_reg.cond))
    else $error("Condition is not exactly one state.");
  a_scale_unity: assert property ((s_reg.mult[0] == ONE_X) |=>
                                  s_reg.scaled[0] == $past(measIn[0]))
    else $error("Unity multiplier altered the measurement.");
  a_start_entry: assert property ((tick && s_reg.cond == ST_NORMAL && pk && !blk
                                   && beh != BM_OFF) |=>
                                  s_reg.cond == ST_START && s_reg.remain == $past(s_reg.opd))
    else $error("Pick-up did not start the operating delay.");
  a_trip_timer: assert property ((tick && s_reg.cond == ST_START && pk && !blk
                                  && s_reg.remain == 21'h1 && beh != BM_OFF) |=>
                                 s_reg.cond == ST_TRIP)
    else $error("Operating delay expired without trip.");
  a_block_pick: assert property ((tick && s_reg.cond == ST_NORMAL && pk && blk
                                  && beh != BM_OFF) |=> s_reg.cond == ST_BLOCKED)
    else $error("Blocked pick-up did not report blocked.");
  a_release_end: assert property ((tick && s_reg.cond == ST_START && !pk
                                   && s_reg.relc == 21'h1) |=> s_reg.cond == ST_NORMAL)
    else $error("Release delay did not end the start.");
  a_hyst_hold: assert property ((tick && s_reg.puf[0] && s_reg.mode[0] == CM_OVER
                                 && $signed(s_reg.scaled[0]) > $signed(s_reg.pu[0])) |=>
                                s_reg.puf[0])
    else $error("Pick-up released above the level.");
  a_remain_max: assert property ((s_reg.cond == ST_START) |-> s_reg.remain <= s_reg.opd)
    else $error("Remaining time exceeds the operating delay.");
  a_off_normal: assert property ((beh == BM_OFF) |=> s_reg.cond == ST_NORMAL)
    else $error("Off mode left the stage active.");
  a_wait_first: assert property ((avs.read && !s_reg.ack) |-> avsWaitRequest ##1
                                 (avs.read ? !avsWaitRequest : 1'b1))
    else $error("Read was not answered after one wait cycle.");
endmodule

// [test/pts_meas_model.sv]
// Model of the measurement front end and blocking matrix that feed the stage.
`timescale 1ns/100ps
module pts_meas_model
  import pts_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [2:0][31:0] setMeas,
  input  wire logic [31:0]      setCalc,
  input  wire logic             setBlock,
  output logic [2:0][31:0]      measIn,
  output logic [31:0]           calcMag,
  output logic                  blockIn
);
  // New values appear just after a clock edge, as a sampled front end delivers them.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      measIn  <= '0;
      calcMag <= '0;
      blockIn <= 1'b0;
    end
    else
    begin
      measIn  <= setMeas;
      calcMag <= setCalc;
      blockIn <= setBlock;
    end
  end
endmodule

// [test/testbench.sv]
// Self-checking testbench of the programmable threshold stage.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import pts_pkg::*;
  localparam int TK = 10;
  localparam pts_stat_t S_IDLE = 3'b000;
  localparam pts_stat_t S_START = 3'b100;
  localparam pts_stat_t S_TRIP = 3'b010;
  localparam pts_stat_t S_BLK = 3'b001;
  typedef struct packed { logic [7:0] addr; logic [31:0] exp; } pts_row_t;
  typedef struct packed { logic [2:0] m; logic [31:0] pu, hit, idle; } pts_crow_t;
  localparam pts_row_t ROWS [14] = '{
    '{A_CTRL, CTRL_RST}, '{A_OPD, 32'h28}, '{A_REL, 32'h3c}, '{A_COND, 32'h1},
    '{A_EXPECT, 32'h28}, '{A_ISTAT, 32'h0}, '{A_IMASK, 32'h0}, '{8'h40, 32'h0},
    '{8'h44, 32'h64}, '{8'h48, 32'h7530}, '{8'h4c, 32'h1_0000}, '{8'h74, 32'h64},
    '{8'h80, 32'h0}, '{8'hfc, 32'h0}};
  localparam pts_crow_t CROWS [4] = '{
    '{3'h0, 32'hffff_ff9c, 32'hffff_ffce, 32'hffff_fe0c},
    '{3'h1, 32'h64, 32'hffff_ff6a, 32'h0},
    '{3'h2, 32'h64, 32'h32, 32'h1f4},
    '{3'h3, 32'h64, 32'hffff_ffce, 32'h1f4}};
  logic             clk;
  logic             srst;
  pts_avs_req_t     avs;
  logic [31:0]      avsReadData;
  logic             avsWaitRequest;
  logic [2:0][31:0] setMeas;
  logic [31:0]      setCalc;
  logic             setBlock;
  logic [2:0][31:0] measIn;
  logic [31:0]      calcMag;
  logic             blockIn;
  logic             indivModeEn;
  pts_stat_t        stat;
  logic             irq;
  logic [31:0]      rd;
  int               errors;
  int               cmp_count;
  int               n;

  pts_programmable_stage #(.TICK_CYCLES(TK)) dut (.clk(clk), .srst(srst), .avs(avs),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .measIn(measIn),
    .calcMag(calcMag), .blockIn(blockIn), .indivModeEn(indivModeEn), .stat(stat),
    .irq(irq));
  pts_meas_model meas (.clk(clk), .srst(srst), .setMeas(setMeas), .setCalc(setCalc),
    .setBlock(setBlock), .measIn(measIn), .calcMag(calcMag), .blockIn(blockIn));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] magA(input int i, input logic [1:0] f);
    return {A_MAG_HI, 2'(i), f, 2'b00};
  endfunction

  // Holds the request until waitrequest is sampled low at a rising edge.
  task automatic avXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk);
    avs <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: d};
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avs <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    avXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] ex);
    avXfer(1'b0, a, 32'h0, rd);
    `CHK($sformatf("reg %h", a), ex, rd)
  endtask

  task automatic ticks(input int k);
    repeat (k * TK) @(posedge clk);
  endtask

  task automatic waitStat(input pts_stat_t want, input int maxc);
    n = 0;
    while (stat !== want && n < maxc)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("stat", want, stat)
  endtask

  task automatic setM0(input logic [31:0] v);
    @(posedge clk);
    setMeas[0] <= v;
  endtask

  task automatic summarize;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end

  initial
  begin
    srst = 1'b1;
    avs = '0;
    setMeas = '0;
    setCalc = '0;
    setBlock = 1'b0;
    indivModeEn = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (ROWS[i]) rdChk(ROWS[i].addr, ROWS[i].exp);
    // A level equal to the pick-up, steady past the delta history, fulfils no mode.
    setM0(32'h64);
    ticks(25);
    for (int m = 0; m < 8; m++)
    begin
      wr(magA(0, F_MODE), 32'(m));
      rdChk(magA(0, F_MODE), 32'(m));
    end
    // Under mode keeps the stage quiet while the readouts are examined.
    wr(magA(0, F_MODE), 32'h2);
    setM0(32'hc8);
    setCalc <= 32'h12c;
    repeat (300) @(posedge clk);
    rdChk({A_SCALED_HI, 4'h0}, 32'hc8);
    rdChk({A_RATIO_HI, 4'h0}, 32'h2_0000);
    rdChk({A_RATIO_HI, 4'hc}, 32'h3_0000);
    wr(magA(0, F_MULT), 32'h2_0000);
    repeat (200) @(posedge clk);
    rdChk({A_SCALED_HI, 4'h0}, 32'h190);
    wr(magA(0, F_MULT), ONE_X);
    setM0(32'h64);
    wr(magA(0, F_MODE), 32'h0);
    wr(A_OPD, 32'h3);
    wr(A_REL, 32'h2);
    wr(A_IMASK, 32'h2);
    rdChk(A_ISTAT, 32'h0);
    setM0(32'h96);
    waitStat(S_START, 3 * TK);
    waitStat(S_TRIP, 6 * TK);
    `CHK("trip delay", 1'b1, 1'(n >= 3 * TK - 1 && n <= 3 * TK + 1))
    `CHK("irq", 1'b1, irq)
    rdChk(A_COND, 32'h4);
    rdChk(A_ISTAT, 32'h3);
    rdChk(A_ISTAT, 32'h0);
    `CHK("irq", 1'b0, irq)
    setM0(32'h62);
    ticks(10);
    `CHK("hold in band", S_TRIP, stat)
    setM0(32'h5a);
    waitStat(S_IDLE, 6 * TK);
    `CHK("release delay", 1'b1, 1'(n >= 2 * TK - 1 && n <= 3 * TK + 1))
    // Two selected measurements must both pick up.
    wr(A_CTRL, 32'h2);
    @(posedge clk);
    setMeas <= {32'h0, 32'h0, 32'h96};
    ticks(10);
    `CHK("one of two", S_IDLE, stat)
    @(posedge clk);
    setMeas[1] <= 32'h96;
    waitStat(S_START, 3 * TK);
    @(posedge clk);
    setMeas <= '0;
    waitStat(S_IDLE, 8 * TK);
    wr(A_CTRL, 32'h1);
    wr(A_OPD, 32'h32);
    foreach (CROWS[i])
    begin
      setM0(CROWS[i].idle);
      wr(magA(0, F_MODE), 32'(CROWS[i].m));
      wr(magA(0, F_PU), CROWS[i].pu);
      ticks(8);
      `CHK("idle", S_IDLE, stat)
      setM0(CROWS[i].hit);
      waitStat(S_START, 3 * TK);
      rdChk(A_COND, 32'h2);
      rdChk(A_EXPECT, 32'h32);
      avXfer(1'b0, A_REMAIN, 32'h0, rd);
      `CHK("remain", 1'b1, 1'(rd > 0 && rd <= 32'h32))
      setM0(CROWS[i].idle);
      waitStat(S_IDLE, 8 * TK);
    end
    wr(magA(0, F_MODE), 32'h7);
    wr(magA(0, F_PU), 32'h64);
    setM0(32'h0);
    ticks(30);
    setM0(32'h1f4);
    waitStat(S_START, 25 * TK);
    waitStat(S_IDLE, 60 * TK);
    wr(magA(0, F_MODE), 32'h6);
    ticks(30);
    setM0(32'h0);
    ticks(30);
    `CHK("signed delta", S_IDLE, stat)
    wr(magA(0, F_MODE), 32'h0);
    wr(A_IMASK, 32'h4);
    avXfer(1'b0, A_ISTAT, 32'h0, rd);
    rdChk(A_ISTAT, 32'h0);
    setBlock <= 1'b1;
    ticks(2);
    setM0(32'h96);
    waitStat(S_BLK, 3 * TK);
    `CHK("irq", 1'b1, irq)
    rdChk(A_COND, 32'h8);
    setM0(32'h0);
    setBlock <= 1'b0;
    waitStat(S_IDLE, 8 * TK);
    for (int b = 0; b < 5; b++)
    begin
      wr(A_CTRL, {27'h0, 3'(b), 2'b01});
      indivModeEn <= 1'b1;
      rdChk(A_COND, {25'h0, 3'(b), 4'h1});
      indivModeEn <= 1'b0;
      rdChk(A_COND, 32'h1);
    end
    summarize();
  end
endmodule
